// file: bench/hdsc_host.sv
/*
  Host controller model for the serial port: frames of 0 to 32 bits.
  Assumes the bench turns the floating serial output into Z.
*/
`timescale 1ns/1ps
`default_nettype none
module hdsc_host (
  output logic sclk,
  output logic chip_select_n,
  output logic serial_in,
  input wire logic so_wire
);
  // ----------------------------------------------------------------
  // Idle levels
  // ----------------------------------------------------------------
  // Clock parks high so the first edge in a frame is a falling one.
  // Non-blocking, so the link is already waiting and sees the select edge.
  initial begin
    sclk <= 1'b1;
    chip_select_n <= 1'b1;
    serial_in <= 1'b0;
  end
  // One frame of n falling edges at 32 ns; output taken at each fall
  task automatic xfer(input int n, input logic [31:0] d, output logic [31:0] q);
    q = 32'h0000_0000;
    chip_select_n = 1'b0;
    #150;
    for (int k = 0; k < n; k++) begin
      serial_in = d[k];
      #16;
      q[k] = so_wire;
      sclk = 1'b0;
      #16;
      sclk = 1'b1;
    end
    #100;
    serial_in = 1'b0; // Released input sits at its pull-down level
    chip_select_n = 1'b1;
    #250;
  endtask : xfer
endmodule : hdsc_host
`default_nettype wire

// file: bench/hdsc_top_asserts.sv
/*
  Checker for hdsc_top: concurrent properties on the top ports only.
  Assumes it is bound into hdsc_top with every port connected by name.
*/
`timescale 1ns/1ps
`default_nettype none
module hdsc_chk #(
  parameter int UL_DELAY = hdsc_pkg::UL_DELAY_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_en_n,
  input wire logic enable_in,
  input wire logic overvoltage_in,
  input wire logic undervoltage_lockout,
  input wire logic [hdsc_pkg::NUM_DRV-1:0] overcurrent_in,
  input wire logic [hdsc_pkg::NUM_DRV-1:0] underload_in,
  input wire logic thermal_warning_in,
  input wire logic [hdsc_pkg::NUM_DRV-1:0] driver_on,
  input wire logic overvoltage_shutdown_enable,
  input wire logic underload_shutdown_enable,
  input wire logic overcurrent_shutdown_enable
);
  import hdsc_pkg::*;
  // ----------------------------------------------------------------
  // Frame edge counter
  // ----------------------------------------------------------------
  // Saturates so long chains never wrap back under one word
  logic [4:0] fall_q;
  always_ff @(negedge sclk or posedge chip_select_n) begin
    if (chip_select_n) begin
      fall_q <= 5'h00;
    end else if (fall_q != 5'h1f) begin
      fall_q <= fall_q + 5'h01;
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  // Output enable tracks chip select, so the line floats between frames
  oe_follows_cs_a: assert property (@(posedge clk) disable iff (!resetn)
    serial_out_en_n == chip_select_n) else $error("serial output enable off chip select");
  // After one word the output repeats the input sixteen edges late
  so_echo_a: assert property (@(negedge sclk) disable iff (!resetn)
    fall_q >= 5'h10 |-> serial_out == $past(serial_in, 16)) else $error("chain echo wrong");
  // Enables only rise after chip select has been high a while
  commit_after_cs_a: assert property (@(posedge clk) disable iff (!resetn)
    $rose(overvoltage_shutdown_enable) || $rose(underload_shutdown_enable) ||
    $rose(overcurrent_shutdown_enable) |-> $past(chip_select_n, 3)) else $error("early commit");
  overvoltage_shutdown_enable_mask_a: assert property (@(posedge clk) disable iff (!resetn)
    (overvoltage_shutdown_enable && overvoltage_in)[*5] |-> driver_on == 12'h000)
    else $error("drivers on in overvoltage");
  undervoltage_lockout_mask_a: assert property (@(posedge clk) disable iff (!resetn)
    undervoltage_lockout[*5] |-> driver_on == 12'h000) else $error("drivers on in undervoltage");
  ocd_latch_a: assert property (@(posedge clk) disable iff (!resetn)
    (overcurrent_shutdown_enable && overcurrent_in[2])[*5] |=> !driver_on[2])
    else $error("over-current driver not off");
  sleep_clears_a: assert property (@(posedge clk) disable iff (!resetn)
    (!enable_in)[*6] |-> driver_on == 12'h000 && !overvoltage_shutdown_enable &&
    !underload_shutdown_enable && !overcurrent_shutdown_enable) else $error("sleep kept data");
  // No disable here: reset itself is the cause being checked
  reset_off_a: assert property (@(posedge clk)
    !resetn |-> driver_on == 12'h000 && !overcurrent_shutdown_enable)
    else $error("outputs on in reset");
endmodule : hdsc_chk
`default_nettype wire

// file: bench/test_hex_driver_spi_control.sv
/*
  Self-checking bench for hdsc_top driven by a host model.
  Assumes the package, design, checker and host model compile first.
*/
`timescale 1ns/1ps
`default_nettype none
module test_hex_driver_spi_control;
  import hdsc_pkg::*;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  localparam int UL = 20; // Short under-load delay keeps the run brief
  logic clk = 1'b0;
  logic resetn;
  logic sclk, chip_select_n, serial_in, serial_out, serial_out_en_n;
  logic enable_in = 1'b1;
  logic overvoltage_in = 1'b0;
  logic undervoltage_lockout = 1'b0;
  logic thermal_warning_in = 1'b1;
  logic [NUM_DRV-1:0] overcurrent_in = 12'h000;
  logic [NUM_DRV-1:0] underload_in = 12'h000;
  logic [NUM_DRV-1:0] driver_on;
  logic overvoltage_shutdown_enable, underload_shutdown_enable, overcurrent_shutdown_enable;
  logic [31:0] q;
  int n_errors = 0;
  int num_checks = 0;
  wire so_wire = serial_out_en_n ? 1'bz : serial_out;
  wire [2:0] ens = {overvoltage_shutdown_enable, underload_shutdown_enable,
                    overcurrent_shutdown_enable};
  always #12.5 clk = ~clk;
  hdsc_top #(.UL_DELAY(UL)) dut (.clk(clk), .resetn(resetn), .sclk(sclk),
    .chip_select_n(chip_select_n), .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_en_n(serial_out_en_n), .enable_in(enable_in),
    .overvoltage_in(overvoltage_in), .undervoltage_lockout(undervoltage_lockout),
    .overcurrent_in(overcurrent_in), .underload_in(underload_in),
    .thermal_warning_in(thermal_warning_in), .driver_on(driver_on),
    .overvoltage_shutdown_enable(overvoltage_shutdown_enable),
    .underload_shutdown_enable(underload_shutdown_enable),
    .overcurrent_shutdown_enable(overcurrent_shutdown_enable));
  hdsc_host host (.sclk(sclk), .chip_select_n(chip_select_n), .serial_in(serial_in),
    .so_wire(so_wire));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wclk(input int n);
    repeat (n) @(posedge clk);
  endtask : wclk
  task automatic give_verdict();
    $display("Checks %0d, errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_basic();
    host.xfer(16, 32'h0000_b556, q);
    check(ens, 32'h5);
    check(driver_on, 32'haab);
    check(so_wire, 1'bz);
    // Warning pin dropped ahead of the frame so status bit 0 must follow it
    @(posedge clk) thermal_warning_in <= 1'b0;
    wclk(3);
    host.xfer(16, 32'h0000_b556, q);
    check(q, 32'h1556);
    @(posedge clk) thermal_warning_in <= 1'b1;
  endtask : t_basic
  // Short, long and empty frames must all leave the settings alone
  task automatic t_refuse();
    int nb[3] = '{15, 17, 0};
    foreach (nb[i]) begin
      host.xfer(nb[i], 32'hffff_ffff, q);
      check({ens, driver_on}, 32'h5aab);
    end
  endtask : t_refuse
  task automatic t_chain();
    host.xfer(32, 32'h200e_5a3c, q);
    check(q[31:16], 32'h5a3c);
    check(q[15:0], 32'h1557);
    check({ens, driver_on}, 32'h1007);
  endtask : t_chain
  task automatic t_overcurrent();
    @(posedge clk) overcurrent_in <= 12'h004;
    wclk(10);
    overcurrent_in <= 12'h000;
    wclk(6);
    check(driver_on, 32'h003);
    host.xfer(16, 32'h0000_200e, q);
    check(q, 32'h2007);
    check(driver_on, 32'h003);
    host.xfer(16, 32'h0000_000f, q);
    check(driver_on, 32'h007);
    @(posedge clk) overcurrent_in <= 12'h004;
    wclk(10);
    overcurrent_in <= 12'h000;
    wclk(6);
    check(driver_on, 32'h007);
    host.xfer(16, 32'h0000_000e, q);
    check(q, 32'h200f);
  endtask : t_overcurrent
  task automatic t_underload();
    // Shutdown disabled: the flag rises but the driver must stay on
    @(posedge clk) underload_in <= 12'h002;
    wclk(UL + 10);
    underload_in <= 12'h000;
    wclk(4);
    check(driver_on, 32'h007);
    host.xfer(16, 32'h0000_400f, q);
    check(q, 32'h600f);
    @(posedge clk) underload_in <= 12'h002;
    wclk(UL + 10);
    underload_in <= 12'h000;
    wclk(4);
    check(driver_on, 32'h005);
    host.xfer(16, 32'h0000_400f, q);
    check(q, 32'h400b);
    check(driver_on, 32'h007);
  endtask : t_underload
  task automatic t_supply();
    host.xfer(16, 32'h0000_800e, q);
    @(posedge clk) overvoltage_in <= 1'b1;
    wclk(6);
    check(driver_on, 32'h000);
    overvoltage_in <= 1'b0;
    wclk(6);
    check(driver_on, 32'h007);
    undervoltage_lockout <= 1'b1;
    wclk(6);
    check(driver_on, 32'h000);
    undervoltage_lockout <= 1'b0;
    wclk(6);
    host.xfer(16, 32'h0000_800f, q);
    check(q, 32'h800f);
  endtask : t_supply
  task automatic t_sleep();
    @(posedge clk) enable_in <= 1'b0;
    wclk(6);
    check({ens, driver_on}, 32'h0);
    host.xfer(16, 32'h0000_800e, q);
    @(posedge clk) enable_in <= 1'b1;
    wclk(6);
    check({ens, driver_on}, 32'h0);
  endtask : t_sleep
  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    resetn <= 1'b0; // Real falling edge, so the serial-clock side resets too
    wclk(16);
    resetn <= 1'b1;
    wclk(4);
    t_basic();
    t_refuse();
    t_chain();
    t_overcurrent();
    t_underload();
    t_supply();
    t_sleep();
    give_verdict();
  end
  // About 18 us of traffic expected; a hang is cut off well after
  initial begin
    #200000;
    n_errors++;
    give_verdict();
  end
endmodule : test_hex_driver_spi_control
bind hdsc_top hdsc_chk #(.UL_DELAY(UL_DELAY)) chk (.clk(clk), .resetn(resetn), .sclk(sclk),
  .chip_select_n(chip_select_n), .serial_in(serial_in), .serial_out(serial_out),
  .serial_out_en_n(serial_out_en_n), .enable_in(enable_in),
  .overvoltage_in(overvoltage_in), .undervoltage_lockout(undervoltage_lockout),
  .overcurrent_in(overcurrent_in), .underload_in(underload_in),
  .thermal_warning_in(thermal_warning_in), .driver_on(driver_on),
  .overvoltage_shutdown_enable(overvoltage_shutdown_enable),
  .underload_shutdown_enable(underload_shutdown_enable),
  .overcurrent_shutdown_enable(overcurrent_shutdown_enable));
`default_nettype wire

// file: hw/hdsc_link.sv
/*
  Serial link end of the hex driver control block, clocked by the serial
  clock. Shifts control bits in and status bits out, LSB first.
  Assumes the host holds the serial clock still while chip select is high
  and that status_snap is steady for the whole frame.
*/
`timescale 1ns/1ps
`default_nettype none
module hdsc_link (
  input wire logic sclk,
  input wire logic resetn,
  input wire logic chip_select_n,
  input wire logic serial_in,
  input wire logic [hdsc_pkg::WORD_BITS-1:0] status_snap,
  output logic [hdsc_pkg::WORD_BITS-1:0] rx_word,
  output logic [hdsc_pkg::CNT_BITS-1:0] bit_count,
  output logic word_done,
  output logic frame_tog,
  output logic serial_out,
  output logic serial_out_en_n
);
  import hdsc_pkg::*;

  logic active_q;
  logic started_q;
  logic so_q;

  // ----------------------------------------------------------------
  // Frame activity
  // ----------------------------------------------------------------
  // Cleared by chip select itself, since no edge comes between frames
  always_ff @(negedge sclk or posedge chip_select_n) begin
    if (chip_select_n) begin
      active_q <= 1'b0;
    end else begin
      active_q <= 1'b1;
    end
  end

  // Input shifter; counts restart at the first edge of each frame
  always_ff @(negedge sclk or negedge resetn) begin
    if (!resetn) begin
      rx_word <= CTRL_RESET;
      bit_count <= '0;
      word_done <= 1'b0;
      frame_tog <= 1'b0;
    end else if (!chip_select_n) begin
      rx_word <= {serial_in, rx_word[WORD_BITS-1:1]};
      if (!active_q) begin
        bit_count <= 4'h1;
        word_done <= 1'b0;
        frame_tog <= ~frame_tog;
      end else begin
        bit_count <= bit_count + 4'h1;
        if (bit_count == 4'hf) begin
          word_done <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Output shifter
  // ----------------------------------------------------------------
  // Status bits first, then the received bits pass through for a chain
  always_ff @(posedge sclk or posedge chip_select_n) begin
    if (chip_select_n) begin
      started_q <= 1'b0;
      so_q <= 1'b0;
    end else begin
      started_q <= 1'b1;
      if (word_done) begin
        so_q <= rx_word[0];
      end else begin
        so_q <= status_snap[bit_count];
      end
    end
  end

  // Bit 0 must be out before any clock edge arrives
  assign serial_out = started_q ? so_q : status_snap[0];
  assign serial_out_en_n = chip_select_n;
endmodule : hdsc_link
`default_nettype wire

// file: hw/hdsc_pkg.sv
/*
  Shared constants for the hex driver serial control block: word layout,
  reset values and timing figures.
  Assumes a 40 MHz system clock; nothing else is needed from outside.
*/
package hdsc_pkg;
  // ----------------------------------------------------------------
  // Word layout
  // ----------------------------------------------------------------
  localparam int WORD_BITS = 16;
  localparam int CNT_BITS = 4;
  localparam int NUM_DRV = 12;
  localparam int BIT_OVERVOLTAGE_SHUTDOWN_ENABLE_EN = 15;
  localparam int BIT_ULD_EN = 14;
  localparam int BIT_OCD_EN = 13;
  localparam int BIT_DRV_LO = 1;
  localparam int BIT_CLEAR = 0;
  localparam int BIT_SUPPLY_FLAG = 15;
  localparam int BIT_UNDERLOAD_FLAG = 14;
  localparam int BIT_OVERLOAD_FLAG = 13;
  localparam int BIT_THERMAL_FLAG = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [WORD_BITS-1:0] CTRL_RESET = 16'h0000;
  localparam logic [NUM_DRV-1:0] DRV_RESET = 12'h000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 40;
  localparam int UL_DELAY_US = 200;
  // Least delay: whole microseconds times MHz is already exact
  localparam int UL_DELAY_CYC = UL_DELAY_US * CLK_MHZ;
  localparam int UL_CNT_BITS = 16;
endpackage : hdsc_pkg

// file: hw/hdsc_top.sv
/*
  Hex driver serial control: command register, fault flags, protection
  latches and driver outputs, plus the serial link end on its own clock.
  Assumes fault inputs and pins are asynchronous levels from analog logic,
  and that the serial clock is slower than the system clock.
*/
//
// Behaviour
// - Sixteen-bit words, least significant bit first
// - Sample serial input on falling clock edges
// - Chip select rising commits shifted bits
// - Serial output floats while chip select high
// - Commit only nonzero multiples of sixteen bits
// - Status word shifts out while commands in
// - Chained devices pass bits through, word each
// - Bit fifteen enables overvoltage shutdown
// - Bit fourteen enables under-load shutdown
// - Bit thirteen enables over-current shutdown
// - Bits one to twelve command six half-bridges
// - Bit zero set clears latched flags
// - Output bits report supply, load, thermal faults
// - Over-current latches driver off when enabled
// - Timed under-load sets flag, optionally latches off
// - Overvoltage forces outputs off, settings kept
// - Sleep forgets control data, drivers off
`timescale 1ns/1ps
`default_nettype none
module hdsc_top #(
  parameter int UL_DELAY = hdsc_pkg::UL_DELAY_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_en_n,
  input wire logic enable_in,
  input wire logic overvoltage_in,
  input wire logic undervoltage_lockout,
  input wire logic [hdsc_pkg::NUM_DRV-1:0] overcurrent_in,
  input wire logic [hdsc_pkg::NUM_DRV-1:0] underload_in,
  input wire logic thermal_warning_in,
  output logic [hdsc_pkg::NUM_DRV-1:0] driver_on,
  output logic overvoltage_shutdown_enable,
  output logic underload_shutdown_enable,
  output logic overcurrent_shutdown_enable
);
  import hdsc_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic csb_s1_q;
  logic csb_s2_q;
  logic csb_prev_q;
  logic tog_s1_q;
  logic tog_s2_q;
  logic tog_start_q;
  logic en_s1_q;
  logic en_s2_q;
  logic ov_s1_q;
  logic ov_s2_q;
  logic uv_s1_q;
  logic uv_s2_q;
  logic tw_s1_q;
  logic tw_s2_q;
  logic [NUM_DRV-1:0] oc_s1_q;
  logic [NUM_DRV-1:0] oc_s2_q;
  logic [NUM_DRV-1:0] ul_s1_q;
  logic [NUM_DRV-1:0] ul_s2_q;

  logic [WORD_BITS-1:0] rx_word;
  logic [CNT_BITS-1:0] bit_count;
  logic word_done;
  logic frame_tog;

  logic frame_open;
  logic frame_close;
  logic accept;
  logic clear_req;

  logic [WORD_BITS-1:0] snap_q;
  logic [WORD_BITS-1:0] status_word;
  logic [NUM_DRV-1:0] drv_cmd_q;
  logic [NUM_DRV-1:0] latch_off_q;
  logic [NUM_DRV-1:0] latch_off_d;
  logic [NUM_DRV-1:0] drv_d;
  logic [NUM_DRV-1:0] ul_hit;
  logic [UL_CNT_BITS-1:0] ul_cnt_q [NUM_DRV];
  logic supply_fault_flag_q;
  logic underload_flag_q;
  logic overload_flag_q;
  logic supply_block;

  localparam logic [UL_CNT_BITS-1:0] UL_LIMIT = UL_CNT_BITS'(UL_DELAY);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Flag update where a new event outweighs a clear in the same cycle
  function automatic logic sticky(input logic cur, input logic set,
                                  input logic clr);
    sticky = set | (cur & ~clr);
  endfunction : sticky

  // ----------------------------------------------------------------
  // Link end on the serial clock
  // ----------------------------------------------------------------
  hdsc_link u_link (
    .sclk(sclk),
    .resetn(resetn),
    .chip_select_n(chip_select_n),
    .serial_in(serial_in),
    .status_snap(snap_q),
    .rx_word(rx_word),
    .bit_count(bit_count),
    .word_done(word_done),
    .frame_tog(frame_tog),
    .serial_out(serial_out),
    .serial_out_en_n(serial_out_en_n)
  );

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  // Chip select and the frame toggle cross as levels
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      csb_s1_q <= 1'b1;
      csb_s2_q <= 1'b1;
      csb_prev_q <= 1'b1;
      tog_s1_q <= 1'b0;
      tog_s2_q <= 1'b0;
    end else begin
      csb_s1_q <= chip_select_n;
      csb_s2_q <= csb_s1_q;
      csb_prev_q <= csb_s2_q;
      tog_s1_q <= frame_tog;
      tog_s2_q <= tog_s1_q;
    end
  end

  // Analog fault levels and the enable pin
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      en_s1_q <= 1'b0;
      en_s2_q <= 1'b0;
      ov_s1_q <= 1'b0;
      ov_s2_q <= 1'b0;
      uv_s1_q <= 1'b0;
      uv_s2_q <= 1'b0;
      tw_s1_q <= 1'b0;
      tw_s2_q <= 1'b0;
      oc_s1_q <= '0;
      oc_s2_q <= '0;
      ul_s1_q <= '0;
      ul_s2_q <= '0;
    end else begin
      en_s1_q <= enable_in;
      en_s2_q <= en_s1_q;
      ov_s1_q <= overvoltage_in;
      ov_s2_q <= ov_s1_q;
      uv_s1_q <= undervoltage_lockout;
      uv_s2_q <= uv_s1_q;
      tw_s1_q <= thermal_warning_in;
      tw_s2_q <= tw_s1_q;
      oc_s1_q <= overcurrent_in;
      oc_s2_q <= oc_s1_q;
      ul_s1_q <= underload_in;
      ul_s2_q <= ul_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Frame decode
  // ----------------------------------------------------------------
  // Edges of the synchronised chip select; the host opens every frame
  assign frame_open = csb_prev_q & ~csb_s2_q;
  assign frame_close = ~csb_prev_q & csb_s2_q;

  // Link outputs are read only after the close, when the serial clock
  // stands still, so the word and count are quasi-static here. The
  // toggle proves that at least one clock edge arrived in this frame.
  assign accept = frame_close & en_s2_q & (tog_s2_q != tog_start_q)
                  & word_done & (bit_count == '0);
  assign clear_req = accept & rx_word[BIT_CLEAR];

  // Toggle state at frame start, compared at frame end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tog_start_q <= 1'b0;
    end else if (frame_open) begin
      tog_start_q <= tog_s2_q;
    end
  end

  // ----------------------------------------------------------------
  // Status snapshot
  // ----------------------------------------------------------------
  // Live status word in output bit order
  always_comb begin
    status_word = CTRL_RESET;
    status_word[BIT_SUPPLY_FLAG] = supply_fault_flag_q;
    status_word[BIT_UNDERLOAD_FLAG] = underload_flag_q;
    status_word[BIT_OVERLOAD_FLAG] = overload_flag_q;
    status_word[BIT_DRV_LO +: NUM_DRV] = driver_on;
    status_word[BIT_THERMAL_FLAG] = tw_s2_q;
  end

  // Frozen at frame start so the shifter never sees a bit change mid-word.
  // The sync delay is about three system clocks, well within the host's
  // chip select setup, so bit 0 settles before the first serial edge.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      snap_q <= CTRL_RESET;
    end else if (frame_open) begin
      snap_q <= status_word;
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  // Committed only on an accepted frame; sleep wipes it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      overvoltage_shutdown_enable <= 1'b0;
      underload_shutdown_enable <= 1'b0;
      overcurrent_shutdown_enable <= 1'b0;
      drv_cmd_q <= DRV_RESET;
    end else if (!en_s2_q) begin
      overvoltage_shutdown_enable <= 1'b0;
      underload_shutdown_enable <= 1'b0;
      overcurrent_shutdown_enable <= 1'b0;
      drv_cmd_q <= DRV_RESET;
    end else if (accept) begin
      overvoltage_shutdown_enable <= rx_word[BIT_OVERVOLTAGE_SHUTDOWN_ENABLE_EN];
      underload_shutdown_enable <= rx_word[BIT_ULD_EN];
      overcurrent_shutdown_enable <= rx_word[BIT_OCD_EN];
      drv_cmd_q <= rx_word[BIT_DRV_LO +: NUM_DRV];
    end
  end

  // ----------------------------------------------------------------
  // Under-load timers
  // ----------------------------------------------------------------
  // One saturating counter per driver; a brief dip restarts the wait,
  // which keeps switching transients from raising the flag
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NUM_DRV; i++) begin
        ul_cnt_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NUM_DRV; i++) begin
        if (!(ul_s2_q[i] & driver_on[i])) begin
          ul_cnt_q[i] <= '0;
        end else if (ul_cnt_q[i] != UL_LIMIT) begin
          ul_cnt_q[i] <= ul_cnt_q[i] + 1'b1;
        end
      end
    end
  end

  // Condition has lasted the full detection delay
  always_comb begin
    for (int i = 0; i < NUM_DRV; i++) begin
      ul_hit[i] = ul_s2_q[i] & driver_on[i] & (ul_cnt_q[i] == UL_LIMIT);
    end
  end

  // ----------------------------------------------------------------
  // Fault flags
  // ----------------------------------------------------------------
  // Set regardless of the shutdown enables; cleared only by bit 0 or by sleep
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      supply_fault_flag_q <= 1'b0;
      underload_flag_q <= 1'b0;
      overload_flag_q <= 1'b0;
    end else if (!en_s2_q) begin
      supply_fault_flag_q <= 1'b0;
      underload_flag_q <= 1'b0;
      overload_flag_q <= 1'b0;
    end else begin
      supply_fault_flag_q <= sticky(supply_fault_flag_q,
                                    ov_s2_q | uv_s2_q, clear_req);
      underload_flag_q <= sticky(underload_flag_q, |ul_hit,
                                 clear_req);
      overload_flag_q <= sticky(overload_flag_q, |oc_s2_q,
                                clear_req);
    end
  end

  // ----------------------------------------------------------------
  // Driver latch-off
  // ----------------------------------------------------------------
  // A tripped driver stays off until a status clear, even if the fault
  // goes away; only enabled shutdowns latch
  always_comb begin
    for (int i = 0; i < NUM_DRV; i++) begin
      latch_off_d[i] = sticky(latch_off_q[i],
                              (overcurrent_shutdown_enable & oc_s2_q[i])
                              | (underload_shutdown_enable & ul_hit[i]),
                              clear_req);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      latch_off_q <= '0;
    end else if (!en_s2_q) begin
      latch_off_q <= '0;
    end else begin
      latch_off_q <= latch_off_d;
    end
  end

  // ----------------------------------------------------------------
  // Driver outputs
  // ----------------------------------------------------------------
  // Overvoltage only masks the outputs; the commanded states survive
  // and come back as soon as the supply is in range again
  assign supply_block = (overvoltage_shutdown_enable & ov_s2_q)
                        | uv_s2_q;

  always_comb begin
    drv_d = drv_cmd_q & ~latch_off_q;
    if (supply_block || !en_s2_q) begin
      drv_d = DRV_RESET;
    end
  end

  // Registered so the pins never glitch on a decode hazard
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      driver_on <= DRV_RESET;
    end else begin
      driver_on <= drv_d;
    end
  end
endmodule : hdsc_top
`default_nettype wire
